// *** hw/lbpc_dev.sv ***
/*
 * device end: counts enable pulses into a current code, runs soft start,
 * boost-mode choice and protection. assumes analog detectors arrive as
 * synchronous levels on clk_sys and the host keeps the power sequence.
 */
`timescale 1ns/1ns
`include "lbpc_defines.svh"
module lbpc_dev
  import lbpc_pkg::*;
#(
  parameter int TOFF_CYC = `LBPC_TOFF_CYC,
  parameter int TACC_CYC = `LBPC_TACC_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  lbpc_link_if.dev link,
  input wire logic undervoltage_lockout,
  input wire logic overvoltage_guard,
  input wire logic overtemperature_shutdown,
  input wire logic out_short,
  input wire logic src_no_reg,
  input wire logic boost_down_ok,
  output logic [4:0] level_code,
  output logic led_on,
  output logic internal_led_enable,
  output logic [1:0] boost_mode,
  output logic pump_run,
  output logic current_limit,
  output logic [7:0] ramp_level
);
  typedef struct packed {
    logic [1:0] en_sync;
    logic [1:0] dim_sync;
    logic en_prev;
    lbpc_dev_st_t st;
    logic [4:0] count;
    logic [4:0] code;
    logic [31:0] tmr;
    logic [31:0] low_tmr;
    logic [7:0] ramp;
    lbpc_boost_t boost;
    logic led_on;
    logic int_en;
    logic pump;
    logic ilim;
  } lbpc_dev_state_t;

  lbpc_dev_state_t state_r;
  lbpc_dev_state_t state_nxt;

  logic en_s;
  logic dim_s;
  logic rise;
  logic fault_off;

  // saturating pulse count; edges past the top code are dropped
  function automatic logic [4:0] lbpc_sat_inc(input logic [4:0] cnt);
    if (cnt < 5'(`LBPC_MAX_CODE)) begin
      return cnt + 5'h01;
    end
    return cnt;
  endfunction

  // one ratio step up; the top ratio holds
  function automatic lbpc_boost_t lbpc_boost_up(input lbpc_boost_t cur);
    unique case (cur)
      LBPC_X1: return LBPC_X1P5;
      LBPC_X1P5: return LBPC_X2;
      default: return LBPC_X2;
    endcase
  endfunction

  // one ratio step down; the bottom ratio holds
  function automatic lbpc_boost_t lbpc_boost_down(input lbpc_boost_t cur);
    unique case (cur)
      LBPC_X2: return LBPC_X1P5;
      LBPC_X1P5: return LBPC_X1;
      default: return LBPC_X1;
    endcase
  endfunction

  // two flops per pin; only the second one is read
  assign en_s = state_r.en_sync[1];
  assign dim_s = state_r.dim_sync[1];
  assign rise = en_s & ~state_r.en_prev;
  // pump stops for heat or overvoltage; recovers alone when cleared
  assign fault_off = overtemperature_shutdown | overvoltage_guard;

  always_comb begin
    state_nxt = state_r;
    state_nxt.en_sync = {state_r.en_sync[0], link.enable_line};
    state_nxt.dim_sync = {state_r.dim_sync[0], link.dimming_gate_input};
    state_nxt.en_prev = en_s;
    // limit tracks the short one cycle late and drops once it clears
    state_nxt.ilim = out_short;
    unique case (state_r.st)
      LBPC_OFF: begin
        // counts cleared while off; the next rise opens an access
        state_nxt.tmr = '0;
        state_nxt.count = '0;
        state_nxt.ramp = '0;
        if (rise) begin
          state_nxt.st = LBPC_ACCESS;
          state_nxt.count = 5'h01;
        end
      end
      LBPC_ACCESS: begin
        // access window runs from the first rise, whatever the line does short of a long low
        state_nxt.tmr = state_r.tmr + 32'h1;
        if (rise) begin
          state_nxt.count = lbpc_sat_inc(state_r.count);
        end
        if (state_r.tmr >= 32'(TACC_CYC)) begin
          // steady high leaves count at 1, the maximum current
          state_nxt.code = state_r.count;
          state_nxt.st = LBPC_RAMP;
          state_nxt.tmr = '0;
        end
      end
      LBPC_RAMP: begin
        state_nxt.int_en = 1'b1;
        // ramp pauses while dimming low, stretching rise by duty
        if (dim_s && !fault_off && state_r.ramp != `LBPC_RAMP_MAX) begin
          state_nxt.ramp = state_r.ramp + 8'h01;
        end
        if (state_r.ramp == `LBPC_RAMP_MAX) begin
          state_nxt.st = LBPC_ON;
        end
      end
      LBPC_ON: begin
        // later pulses step the code further toward the dimmest level
        if (rise) begin
          state_nxt.count = lbpc_sat_inc(state_r.count);
          state_nxt.code = lbpc_sat_inc(state_r.count);
        end
      end
      default: state_nxt.st = LBPC_OFF;
    endcase
    // low timer runs apart from the access window, so the gaps
    // between pulses of a long code never add up to a long low
    if (state_r.st != LBPC_OFF) begin
      state_nxt.low_tmr = en_s ? 32'h0 : state_r.low_tmr + 32'h1;
      if (!en_s && state_r.low_tmr >= 32'(TOFF_CYC)) begin
        state_nxt.st = LBPC_OFF;
        state_nxt.int_en = 1'b0;
        state_nxt.code = '0;
        state_nxt.count = '0;
        state_nxt.tmr = '0;
      end
    end else begin
      state_nxt.low_tmr = '0;
    end
    // lowest ratio that still regulates
    if (src_no_reg && state_r.boost != LBPC_X2) begin
      state_nxt.boost = lbpc_boost_up(state_r.boost);
    end else if (!src_no_reg && boost_down_ok && state_r.boost != LBPC_X1) begin
      state_nxt.boost = lbpc_boost_down(state_r.boost);
    end
    // pump follows the internal enable, held off under faults
    state_nxt.pump = state_r.int_en && !fault_off;
    // gating only after ramp is done
    state_nxt.led_on = state_r.int_en && !fault_off &&
      (state_r.st == LBPC_RAMP || dim_s);
    // undervoltage wipes every field, boost ratio included
    if (undervoltage_lockout) begin
      state_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // each output read straight from the state register
  assign level_code = state_r.code;
  assign led_on = state_r.led_on;
  assign internal_led_enable = state_r.int_en;
  assign boost_mode = state_r.boost;
  assign pump_run = state_r.pump;
  assign current_limit = state_r.ilim;
  assign ramp_level = state_r.ramp;
endmodule

// *** include/lbpc_defines.svh ***
/*
 * timing counts and code limits shared by both ends of the single-wire
 * brightness link. assumes a 100 MHz system clock on both ends.
 */
`ifndef LBPC_DEFINES_SVH
`define LBPC_DEFINES_SVH
`define LBPC_CLK_MHZ 100
`define LBPC_TOFF_US 1000
`define LBPC_TOFF_CYC (`LBPC_TOFF_US * `LBPC_CLK_MHZ)
`define LBPC_TLAT_US 1000
`define LBPC_TLAT_CYC (`LBPC_TLAT_US * `LBPC_CLK_MHZ)
`define LBPC_TACC_US 1000
`define LBPC_TACC_CYC (`LBPC_TACC_US * `LBPC_CLK_MHZ)
`define LBPC_THI_NS 50
`define LBPC_THI_CYC ((`LBPC_THI_NS + 9) / 10)
`define LBPC_TLO_NS 300
`define LBPC_TLO_CYC ((`LBPC_TLO_NS + 9) / 10)
`define LBPC_DIMHI_US 120
`define LBPC_DIMHI_CYC (`LBPC_DIMHI_US * `LBPC_CLK_MHZ)
`define LBPC_MAX_CODE 16
`define LBPC_RAMP_MAX 8'hFF
`endif

// *** include/lbpc_pkg.sv ***
/*
 * types for the brightness link: boost modes, device states and host states.
 * assumes lbpc_defines.svh supplies the numeric constants.
 */
package lbpc_pkg;
  typedef enum logic [1:0] {LBPC_X1, LBPC_X1P5, LBPC_X2} lbpc_boost_t;
  typedef enum logic [2:0] {LBPC_OFF, LBPC_ACCESS, LBPC_RAMP, LBPC_ON} lbpc_dev_st_t;
  typedef enum logic [2:0] {LBPC_H_IDLE, LBPC_H_WAIT, LBPC_H_HI, LBPC_H_LO, LBPC_H_RST} lbpc_host_st_t;
endpackage

// *** include/lbpc_link_if.sv ***
/*
 * link between host and device: enable line and dimming gate line.
 * assumes both ends share clk_sys; host drives both wires.
 */
`timescale 1ns/1ns
interface lbpc_link_if;
  logic enable_line;
  logic dimming_gate_input;
  modport host (output enable_line, output dimming_gate_input);
  modport dev (input enable_line, input dimming_gate_input);
endinterface

// *** hw/lbpc_host.sv ***
/*
 * host end: sends a level code as enable pulses, drives the dimming gate,
 * and resets the device by a long low. assumes supply_good reports a
 * settled supply; pulse timing uses fixed minimum high/low counts.
 */
`timescale 1ns/1ns
`include "lbpc_defines.svh"
module lbpc_host
  import lbpc_pkg::*;
#(
  parameter int TOFF_CYC = `LBPC_TOFF_CYC,
  parameter int TACC_CYC = `LBPC_TACC_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  lbpc_link_if.host link,
  input wire logic supply_good,
  input wire logic set_req,
  input wire logic [4:0] set_code,
  input wire logic off_req,
  input wire logic dim_in,
  output logic busy
);
  typedef struct packed {
    lbpc_host_st_t st;
    logic en;
    logic dim;
    logic [4:0] left;
    logic [31:0] tmr;
    logic busy;
  } lbpc_host_state_t;

  lbpc_host_state_t state_r;
  lbpc_host_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.tmr = state_r.tmr + 32'h1;
    state_nxt.dim = dim_in;
    unique case (state_r.st)
      LBPC_H_IDLE: begin
        state_nxt.busy = 1'b0;
        if (off_req) begin
          state_nxt.st = LBPC_H_RST;
          state_nxt.en = 1'b0;
          state_nxt.tmr = '0;
          state_nxt.busy = 1'b1;
        end else if (set_req && supply_good) begin
          state_nxt.left = (set_code == 5'h00) ? 5'h01 : set_code;
          state_nxt.st = state_r.en ? LBPC_H_LO : LBPC_H_HI;
          state_nxt.en = state_r.en ? 1'b0 : 1'b1;
          state_nxt.tmr = '0;
          state_nxt.busy = 1'b1;
        end
      end
      LBPC_H_HI: begin
        if (state_r.tmr >= 32'(`LBPC_THI_CYC)) begin
          state_nxt.left = state_r.left - 5'h01;
          state_nxt.tmr = '0;
          if (state_r.left == 5'h01) begin
            state_nxt.st = LBPC_H_WAIT;
          end else begin
            state_nxt.st = LBPC_H_LO;
            state_nxt.en = 1'b0;
          end
        end
      end
      LBPC_H_LO: begin
        if (state_r.tmr >= 32'(`LBPC_TLO_CYC)) begin
          state_nxt.st = LBPC_H_HI;
          state_nxt.en = 1'b1;
          state_nxt.tmr = '0;
        end
      end
      LBPC_H_WAIT: begin
        // hold high until the device latches the code
        if (state_r.tmr >= 32'(TACC_CYC)) begin
          state_nxt.st = LBPC_H_IDLE;
        end
      end
      LBPC_H_RST: begin
        if (state_r.tmr > 32'(TOFF_CYC)) begin
          state_nxt.st = LBPC_H_IDLE;
        end
      end
      default: state_nxt.st = LBPC_H_IDLE;
    endcase
    if (!supply_good) begin
      state_nxt.en = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign link.enable_line = state_r.en;
  assign link.dimming_gate_input = state_r.dim;
  assign busy = state_r.busy;
endmodule

// *** dv/lbpc_asserts.sv ***
/* checker for the brightness link and the device outputs.
   assumes the bench instantiates it beside the link interface. */
`timescale 1ns/1ns
`include "lbpc_defines.svh"
module lbpc_asserts #(
  parameter int TOFF_CYC = `LBPC_TOFF_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic enable_line,
  input wire logic undervoltage_lockout,
  input wire logic overvoltage_guard,
  input wire logic overtemperature_shutdown,
  input wire logic out_short,
  input wire logic src_no_reg,
  input wire logic boost_down_ok,
  input wire logic [4:0] level_code,
  input wire logic led_on,
  input wire logic [1:0] boost_mode,
  input wire logic pump_run,
  input wire logic current_limit,
  input wire logic [7:0] ramp_level
);
  int low_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk_sys) begin
    low_r <= (sys_rst || enable_line) ? 0 : low_r + 1;
  end
  // margin covers the input synchroniser and the latch stage
  sequence long_low_s;
    low_r == TOFF_CYC + 5;
  endsequence
  lockout_clear_a: assert property (undervoltage_lockout |=> level_code == 5'h00 && !led_on && !pump_run)
    else $error("state kept under undervoltage");
  code_cap_a: assert property (level_code <= 5'h10)
    else $error("level code above sixteen");
  short_limit_a: assert property (out_short |=> current_limit)
    else $error("no current limit on shorted output");
  guard_pump_a: assert property (overvoltage_guard |=> !pump_run)
    else $error("pump runs under overvoltage");
  heat_led_a: assert property (overtemperature_shutdown |=> !led_on)
    else $error("led on while overheated");
  boost_up_a: assert property (
    boost_mode > $past(boost_mode) |-> $past(src_no_reg) && boost_mode == $past(boost_mode) + 2'h1)
    else $error("boost stepped up without cause");
  boost_rise_a: assert property (
    src_no_reg && boost_mode != 2'h2 && !undervoltage_lockout
    |=> boost_mode == $past(boost_mode) + 2'h1)
    else $error("boost ratio not raised");
  boost_fall_a: assert property (
    !src_no_reg && boost_down_ok && boost_mode != 2'h0 && !undervoltage_lockout
    |=> boost_mode == $past(boost_mode) - 2'h1)
    else $error("boost ratio not lowered");
  ramp_step_a: assert property (ramp_level > $past(ramp_level) |-> ramp_level == $past(ramp_level) + 8'h01)
    else $error("soft start jumped");
  off_timeout_a: assert property (long_low_s |-> level_code == 5'h00 && !led_on)
    else $error("device kept state after long low");
endmodule

// *** dv/test_led_brightness_pulse_control.sv ***
/* self-checking bench: host and device ends joined by the link.
   assumes short timeout and access counts set below. */
`timescale 1ns/1ns
module test_led_brightness_pulse_control;
  localparam int TOFF = 50;
  // long enough for sixteen pulses of 37 cycles
  localparam int TACC = 800;
  logic clk_sys = 0, sys_rst = 1, supply_good = 1, set_req = 0, off_req = 0, dim_in = 1, busy;
  logic undervoltage_lockout = 0, overvoltage_guard = 0, overtemperature_shutdown = 0;
  logic out_short = 0, src_no_reg = 0, boost_down_ok = 0, led_on, internal_led_enable, pump_run, current_limit;
  logic [4:0] set_code = 5'h00, level_code;
  logic [1:0] boost_mode;
  logic [7:0] ramp_level;
  int error_cnt = 0, total_checks = 0, n;
  int codes[$] = '{0, 1, 16, 20, 7};
  lbpc_link_if link();
  lbpc_host #(.TOFF_CYC(TOFF), .TACC_CYC(TACC)) lbpc_host_i (.clk_sys, .sys_rst, .link(link.host),
    .supply_good, .set_req, .set_code, .off_req, .dim_in, .busy);
  lbpc_dev #(.TOFF_CYC(TOFF), .TACC_CYC(TACC)) lbpc_dev_i (.clk_sys, .sys_rst, .link(link.dev),
    .undervoltage_lockout, .overvoltage_guard, .overtemperature_shutdown, .out_short, .src_no_reg,
    .boost_down_ok, .level_code, .led_on, .internal_led_enable, .boost_mode, .pump_run, .current_limit,
    .ramp_level);
  lbpc_asserts #(.TOFF_CYC(TOFF)) lbpc_asserts_i (.clk_sys, .sys_rst, .enable_line(link.enable_line),
    .undervoltage_lockout, .overvoltage_guard, .overtemperature_shutdown, .out_short, .src_no_reg,
    .boost_down_ok, .level_code, .led_on, .boost_mode, .pump_run, .current_limit, .ramp_level);
  always #5 clk_sys = ~clk_sys;
  // shorts only while the host is busy, so brightness checks stay clean
  always @(posedge clk_sys) begin
    src_no_reg <= 1'($urandom_range(0, 1));
    boost_down_ok <= 1'($urandom_range(0, 1));
    out_short <= busy & 1'($urandom_range(0, 1));
  end
  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic req(logic off, logic [4:0] code);
    int t;
    t = 0;
    set_code <= code;
    set_req <= !off;
    off_req <= off;
    while (busy !== 1'b1 && t < 50) begin
      cyc(1);
      t++;
    end
    set_req <= 0;
    off_req <= 0;
    while (busy !== 1'b0 && t < 4000) begin
      cyc(1);
      t++;
    end
    chk("busy", 8'(busy), 8'h00);
  endtask
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h6C10FEFA));
    cyc(20);
    sys_rst <= 0;
    cyc(2);
    codes.push_back($urandom_range(2, 15));
    foreach (codes[i]) begin
      req(1, 5'h00);
      chk("off code", 8'(level_code), 8'h00);
      if (i == 0)
        dim_in <= 0;
      req(0, codes[i][4:0]);
      if (i == 0) begin
        cyc(TACC + 300);
        chk("stalled ramp", ramp_level, 8'h00);
        chk("ramp led", 8'(led_on), 8'h01);
        dim_in <= 1;
      end
      n = 0;
      while (ramp_level !== 8'hFF && n < 3000) begin
        cyc(1);
        n++;
      end
      cyc(3);
      chk("code", 8'(level_code), 8'(codes[i] == 0 ? 1 : codes[i] > 16 ? 16 : codes[i]));
      chk("led enable", 8'(internal_led_enable), 8'h01);
      dim_in <= 0;
      cyc(5);
      chk("dim low", 8'(led_on), 8'h00);
      dim_in <= 1;
      cyc(5);
      chk("dim high", 8'(led_on), 8'h01);
      overtemperature_shutdown <= i[0];
      overvoltage_guard <= !i[0];
      cyc(3);
      chk("fault led", 8'(led_on), 8'h00);
      overtemperature_shutdown <= 0;
      overvoltage_guard <= 0;
      cyc(6);
      chk("resume led", 8'(led_on), 8'h01);
      chk("resume pump", 8'(pump_run), 8'h01);
    end
    supply_good <= 0;
    cyc(3);
    chk("supply low enable", 8'(link.enable_line), 8'h00);
    undervoltage_lockout <= 1;
    cyc(3);
    chk("lockout code", 8'(level_code), 8'h00);
    chk("lockout boost", 8'(boost_mode), 8'h00);
    end_of_test();
  end
endmodule
